// *** rtl/vecarb_pkg.sv ***
// Package with constants and types for the valve external command arbiter
package vecarb_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DEBOUNCE_US = 2000;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int unsigned SS_LOW_MS = 50;
  localparam int unsigned SS_LOW_CYC = (CLK_HZ / 1000) * SS_LOW_MS;
  localparam int unsigned SS_HIGH_MS = 250;
  localparam int unsigned SS_HIGH_CYC = (CLK_HZ / 1000) * SS_HIGH_MS;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned NCMD = 6;
  // Command bit positions after synchronising
  localparam int unsigned B_OPEN = 0;
  localparam int unsigned B_CLOSE = 1;
  localparam int unsigned B_STOP = 2;
  localparam int unsigned B_SOFT = 3;
  localparam int unsigned B_POS = 4;
  localparam int unsigned B_LOWR = 5;
  localparam logic [5:0] CMD_IDLE = 6'h00;

  typedef enum logic [2:0]
  {
    VECARB_AUTO = 3'b000,
    VECARB_OPEN = 3'b001,
    VECARB_CLOSE = 3'b010,
    VECARB_HOLD = 3'b011,
    VECARB_SOFT = 3'b100,
    VECARB_POS = 3'b101
  } vecarb_mode_t;
endpackage

// *** rtl/vecarb_top.sv ***
// Command arbiter for the active-low external valve command lines
`timescale 1ns/10ps
module vecarb_top
  #(
    parameter int unsigned DEBOUNCE_CYCLES = vecarb_pkg::DEBOUNCE_CYC,
    parameter int unsigned SS_LOW_CYCLES = vecarb_pkg::SS_LOW_CYC,
    parameter int unsigned SS_HIGH_CYCLES = vecarb_pkg::SS_HIGH_CYC
  )
  (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic open_cmd_n,
    input wire logic close_cmd_n,
    input wire logic stop_cmd_n,
    input wire logic softstart_cmd_n,
    input wire logic position_target_mode_n,
    input wire logic low_range_cmd_n,
    input wire logic remote_mode_sel,
    input wire logic input_range_selector,
    input wire logic error_positive,
    input wire logic at_open_limit,
    input wire logic at_close_limit,
    output logic [2:0] mode,
    output logic drive_open,
    output logic drive_close,
    output logic valve_hold,
    output logic reduced_speed,
    output logic manual_mode,
    output logic position_target_mode,
    output logic full_scale_1v
  );

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [3:0] q1;
    logic [3:0] q2;
    logic [5:0] deb;
    logic [5:0][vecarb_pkg::CNT_W-1:0] dcnt;
    logic [vecarb_pkg::CNT_W-1:0] hi_cnt;
    logic [vecarb_pkg::CNT_W-1:0] lo_cnt;
    logic armed;
    logic err_prev;
    vecarb_pkg::vecarb_mode_t mode;
    logic drv_open;
    logic drv_close;
    logic hold;
    logic slow;
    logic manual;
    logic pos;
    logic lowr;
  } vecarb_state_t;

  vecarb_state_t st_r;
  vecarb_state_t st_nxt;

  function automatic logic [vecarb_pkg::CNT_W-1:0] sat_inc(input logic [vecarb_pkg::CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  logic [5:0] raw;
  assign raw = ~{low_range_cmd_n, position_target_mode_n, softstart_cmd_n,
                 stop_cmd_n, close_cmd_n, open_cmd_n};

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    logic enable;
    logic [5:0] c;
    logic o;
    logic cl;
    logic sp;
    logic man;
    logic stopped;
    logic ss_exit;
    enable = 1'b0;
    c = '0;
    o = 1'b0;
    cl = 1'b0;
    sp = 1'b0;
    man = 1'b0;
    stopped = 1'b0;
    ss_exit = 1'b0;
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.q1 = {error_positive, input_range_selector, remote_mode_sel, 1'b0};
    st_nxt.q2 = st_r.q1;
    // Debounce: a line must stay steady the full window before it counts
    for (int i = 0; i < vecarb_pkg::NCMD; i++)
    begin
      if (st_r.s2[i] == st_r.deb[i])
      begin
        st_nxt.dcnt[i] = '0;
      end
      else if (st_r.dcnt[i] >= vecarb_pkg::CNT_W'(DEBOUNCE_CYCLES - 1))
      begin
        st_nxt.dcnt[i] = '0;
        st_nxt.deb[i] = st_r.s2[i];
      end
      else
      begin
        st_nxt.dcnt[i] = st_r.dcnt[i] + 1'b1;
      end
    end
    enable = st_r.q2[1] && !st_r.q2[2];
    c = enable ? st_r.deb : vecarb_pkg::CMD_IDLE;
    o = c[vecarb_pkg::B_OPEN];
    cl = c[vecarb_pkg::B_CLOSE];
    sp = c[vecarb_pkg::B_STOP];
    man = o | cl | sp;
    stopped = sp | (o & cl);
    st_nxt.err_prev = st_r.q2[3];
    ss_exit = (st_r.q2[3] != st_r.err_prev) || man;
    // Re-arm timing on the softstart line
    if (c[vecarb_pkg::B_SOFT])
    begin
      st_nxt.lo_cnt = sat_inc(st_r.lo_cnt);
      st_nxt.hi_cnt = '0;
    end
    else
    begin
      st_nxt.hi_cnt = sat_inc(st_r.hi_cnt);
      if (st_r.lo_cnt >= vecarb_pkg::CNT_W'(SS_LOW_CYCLES) || st_r.hi_cnt >= vecarb_pkg::CNT_W'(SS_HIGH_CYCLES))
      begin
        st_nxt.armed = st_r.hi_cnt >= vecarb_pkg::CNT_W'(SS_HIGH_CYCLES) || st_r.armed;
      end
      st_nxt.lo_cnt = '0;
    end
    // Mode arbitration
    if (stopped)
    begin
      st_nxt.mode = vecarb_pkg::VECARB_HOLD;
    end
    else if (o)
    begin
      st_nxt.mode = vecarb_pkg::VECARB_OPEN;
    end
    else if (cl)
    begin
      st_nxt.mode = vecarb_pkg::VECARB_CLOSE;
    end
    else if (st_r.mode == vecarb_pkg::VECARB_SOFT && !ss_exit)
    begin
      st_nxt.mode = vecarb_pkg::VECARB_SOFT;
    end
    else if (c[vecarb_pkg::B_SOFT] && st_r.armed && !st_r.manual && st_r.lo_cnt >= vecarb_pkg::CNT_W'(SS_LOW_CYCLES))
    begin
      st_nxt.mode = vecarb_pkg::VECARB_SOFT;
      st_nxt.armed = 1'b0;
    end
    else if (c[vecarb_pkg::B_POS])
    begin
      st_nxt.mode = vecarb_pkg::VECARB_POS;
    end
    else
    begin
      st_nxt.mode = vecarb_pkg::VECARB_AUTO;
    end
    st_nxt.manual = man;
    st_nxt.drv_open = (st_nxt.mode == vecarb_pkg::VECARB_OPEN) && !at_open_limit;
    st_nxt.drv_close = (st_nxt.mode == vecarb_pkg::VECARB_CLOSE) && !at_close_limit;
    st_nxt.hold = st_nxt.mode == vecarb_pkg::VECARB_HOLD
                  || (st_nxt.mode == vecarb_pkg::VECARB_OPEN && at_open_limit)
                  || (st_nxt.mode == vecarb_pkg::VECARB_CLOSE && at_close_limit);
    st_nxt.slow = st_nxt.mode == vecarb_pkg::VECARB_SOFT;
    // Position target: 0 % set point is open, 100 % is closed, in the analog path
    st_nxt.pos = st_nxt.mode == vecarb_pkg::VECARB_POS;
    st_nxt.lowr = c[vecarb_pkg::B_LOWR];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign mode = st_r.mode;
  assign drive_open = st_r.drv_open;
  assign drive_close = st_r.drv_close;
  assign valve_hold = st_r.hold;
  assign reduced_speed = st_r.slow;
  assign manual_mode = st_r.manual;
  assign position_target_mode = st_r.pos;
  assign full_scale_1v = st_r.lowr;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_not_remote_auto: assert property (@(posedge clk) disable iff (sys_rst)
    (!st_r.q2[1] && mode != vecarb_pkg::VECARB_SOFT) |=> (mode == vecarb_pkg::VECARB_AUTO && !manual_mode))
    else $error("commands acted on outside remote");
  a_range1v_ignore: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.q2[2] |=> !full_scale_1v && !manual_mode)
    else $error("commands acted on with 1 V range selector");
  a_stop_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.q2[1] && !st_r.q2[2] && st_r.deb[vecarb_pkg::B_STOP]) |=> valve_hold && !reduced_speed)
    else $error("stop did not hold valve");
  a_open_limit: assert property (@(posedge clk) disable iff (sys_rst)
    drive_open |-> !$past(at_open_limit))
    else $error("opening past open limit");
  a_close_drive: assert property (@(posedge clk) disable iff (sys_rst)
    drive_close |-> mode == 3'b010 && !valve_hold)
    else $error("close drive inconsistent");
  a_manual_flag: assert property (@(posedge clk) disable iff (sys_rst)
    manual_mode |-> (mode == 3'b001 || mode == 3'b010 || mode == 3'b011))
    else $error("manual flag without manual mode");
  a_soft_excl: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(reduced_speed) |-> !$past(manual_mode))
    else $error("softstart entered under a command");
  a_pos_mode: assert property (@(posedge clk) disable iff (sys_rst)
    position_target_mode |-> !manual_mode)
    else $error("position mode during manual command");
endmodule

// *** tb/vecarb_host_model.sv ***
// Host side model driving the active-low command pins
`timescale 1ns/10ps
module vecarb_host_model
  (
    input wire logic [5:0] cmd,
    output logic open_cmd_n,
    output logic close_cmd_n,
    output logic stop_cmd_n,
    output logic softstart_cmd_n,
    output logic position_target_mode_n,
    output logic low_range_cmd_n
  );
  // Asserted bit grounds its pin, else the pin is driven high
  assign {low_range_cmd_n, position_target_mode_n, softstart_cmd_n, stop_cmd_n, close_cmd_n, open_cmd_n} = ~cmd;
endmodule

// *** tb/tb_vecarb_top.sv ***
// Self-checking bench for the valve command arbiter
`timescale 1ns/10ps
module tb_vecarb_top;
  localparam int DEB = 4;
  localparam int ST = DEB + 6;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] cmd = 6'h00;
  logic remote = 1'b1;
  logic rng = 1'b0;
  logic errp = 1'b0;
  logic lim_o = 1'b0;
  logic lim_c = 1'b0;
  logic o_n, c_n, s_n, ss_n, p_n, l_n;
  logic [2:0] mode;
  logic d_o, d_c, hold, slow, man, pos, fs1;
  int failures = 0;
  int checks = 0;
  always #20 clk = ~clk;
  vecarb_host_model host_u (.cmd(cmd), .open_cmd_n(o_n), .close_cmd_n(c_n), .stop_cmd_n(s_n),
    .softstart_cmd_n(ss_n), .position_target_mode_n(p_n), .low_range_cmd_n(l_n));
  vecarb_top #(.DEBOUNCE_CYCLES(DEB), .SS_LOW_CYCLES(20), .SS_HIGH_CYCLES(40)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .open_cmd_n(o_n), .close_cmd_n(c_n), .stop_cmd_n(s_n), .softstart_cmd_n(ss_n),
    .position_target_mode_n(p_n), .low_range_cmd_n(l_n), .remote_mode_sel(remote),
    .input_range_selector(rng), .error_positive(errp), .at_open_limit(lim_o), .at_close_limit(lim_c),
    .mode(mode), .drive_open(d_o), .drive_close(d_c), .valve_hold(hold), .reduced_speed(slow),
    .manual_mode(man), .position_target_mode(pos), .full_scale_1v(fs1));
  // ----
  // Helpers
  // ----
  task automatic chk_mode(input string nm, input logic [2:0] e);
    checks++;
    if (mode !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, mode);
    end
  endtask
  task automatic chk_bit(input string nm, input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask
  // Sample 1 ns after the edge so registered outputs have landed
  task automatic go(input logic [5:0] c, input int n);
    @(posedge clk) cmd <= c;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_manual();
    go(6'h00, ST);
    chk_mode("auto", vecarb_pkg::VECARB_AUTO);
    // Pulse shorter than the debounce window must not act
    go(6'h01, 2);
    go(6'h00, 1);
    chk_mode("glitch", vecarb_pkg::VECARB_AUTO);
    chk_bit("glitch_manual", man, 1'b0);
    go(6'h01, ST);
    chk_mode("open", vecarb_pkg::VECARB_OPEN);
    chk_bit("drv_open", d_o, 1'b1);
    chk_bit("manual", man, 1'b1);
    @(posedge clk) lim_o <= 1'b1;
    go(6'h01, 3);
    chk_bit("drv_open_lim", d_o, 1'b0);
    chk_bit("hold_lim", hold, 1'b1);
    @(posedge clk) lim_o <= 1'b0;
    go(6'h02, ST);
    chk_bit("drv_close", d_c, 1'b1);
    @(posedge clk) lim_c <= 1'b1;
    go(6'h02, 3);
    chk_mode("close_lim", vecarb_pkg::VECARB_CLOSE);
    chk_bit("drv_close_lim", d_c, 1'b0);
    @(posedge clk) lim_c <= 1'b0;
    go(6'h0C, ST);
    chk_mode("stop", vecarb_pkg::VECARB_HOLD);
    go(6'h0B, ST);
    chk_mode("open_close", vecarb_pkg::VECARB_HOLD);
    chk_bit("slow_held", slow, 1'b0);
    go(6'h00, ST);
    chk_bit("manual_off", man, 1'b0);
    $display("test manual done");
  endtask
  task automatic t_soft();
    go(6'h00, 45);
    go(6'h08, 20 + ST);
    chk_mode("soft", vecarb_pkg::VECARB_SOFT);
    chk_bit("slow", slow, 1'b1);
    @(posedge clk) errp <= 1'b1;
    go(6'h08, ST);
    chk_mode("soft_err_exit", vecarb_pkg::VECARB_AUTO);
    go(6'h00, 45);
    go(6'h08, 20 + ST);
    chk_mode("soft_rearm", vecarb_pkg::VECARB_SOFT);
    go(6'h0C, ST);
    chk_mode("soft_stop_exit", vecarb_pkg::VECARB_HOLD);
    go(6'h00, 45);
    go(6'h0A, 20 + ST);
    chk_mode("soft_blocked", vecarb_pkg::VECARB_CLOSE);
    chk_bit("slow_blocked", slow, 1'b0);
    // Close released with softstart still low: softstart may start now
    go(6'h08, ST);
    chk_mode("soft_released", vecarb_pkg::VECARB_SOFT);
    chk_bit("slow_released", slow, 1'b1);
    @(posedge clk) errp <= 1'b0;
    go(6'h08, ST);
    chk_mode("soft_err_fall", vecarb_pkg::VECARB_AUTO);
    $display("test soft done");
  endtask
  task automatic t_pos_range();
    go(6'h10, ST);
    chk_mode("pos", vecarb_pkg::VECARB_POS);
    chk_bit("pos_flag", pos, 1'b1);
    go(6'h11, ST);
    chk_mode("pos_override", vecarb_pkg::VECARB_OPEN);
    go(6'h30, ST);
    chk_mode("pos_resume", vecarb_pkg::VECARB_POS);
    chk_bit("fs1v", fs1, 1'b1);
    go(6'h00, ST);
    chk_bit("fs10v", fs1, 1'b0);
    $display("test pos_range done");
  endtask
  task automatic t_ignore();
    @(posedge clk) remote <= 1'b0;
    go(6'h01, ST);
    chk_mode("local", vecarb_pkg::VECARB_AUTO);
    @(posedge clk) remote <= 1'b1;
    rng <= 1'b1;
    go(6'h04, ST);
    chk_mode("range_1v", vecarb_pkg::VECARB_AUTO);
    @(posedge clk) rng <= 1'b0;
    go(6'h00, ST);
    $display("test ignore done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_manual();
    t_soft();
    t_pos_range();
    t_ignore();
    end_of_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
